// ===== rtl/nvrtc_pkg.sv
/*
 * constants, command codes and carrier structs for the host-side controller
 * of a byte-wide nonvolatile memory with clock registers.
 * assumes: one 200 MHz clock; device pins are asynchronous to it.
 */
package nvrtc_pkg;
    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int WRITE_PULSE_NS = 30;         // longest grade
    localparam int DATA_SETUP_NS = 15;          // data_setup_to_strobe_end
    localparam int CYCLE_NS = 45;
    localparam int STORE_DURATION_MS = 10;
    localparam int RECALL_DURATION_US = 20;
    localparam int POWERUP_RECALL_DURATION_US = 550;
    localparam int PULSE_CYC = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETUP_CYC = (DATA_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int GAP_CYC = (CYCLE_NS * CLK_MHZ + 999) / 1000 - PULSE_CYC;
    localparam int STORE_CYC = STORE_DURATION_MS * 1000 * CLK_MHZ;
    localparam int RECALL_CYC = RECALL_DURATION_US * CLK_MHZ;
    localparam int RESTORE_CYC = POWERUP_RECALL_DURATION_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // device map
    // ----------------------------------------------------------------
    localparam logic [14:0] CTRL_ADDR = 15'h7ff8;
    localparam logic [14:0] SECONDS_ADDR = 15'h7ff9;
    localparam logic [14:0] DAY_ADDR = 15'h7ffc;
    localparam int CTRL_WRITE_BIT = 7;
    localparam int CTRL_READ_BIT = 6;
    localparam int DAY_FT_BIT = 6;
    localparam logic [13:0] SEQ0 = 14'h0e38;
    localparam logic [13:0] SEQ1 = 14'h31c7;
    localparam logic [13:0] SEQ2 = 14'h03e0;
    localparam logic [13:0] SEQ3 = 14'h3c1f;
    localparam logic [13:0] SEQ4 = 14'h303f;
    localparam logic [13:0] SEQ_STORE = 14'h0fc0;
    localparam logic [13:0] SEQ_RECALL = 14'h0c63;

    // ----------------------------------------------------------------
    // host register map (word index on the command port)
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CMD = 4'h0;      // write: go
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_WDATA = 4'h2;
    localparam logic [3:0] REG_RDATA = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [2:0] CMD_READ = 3'h0;
    localparam logic [2:0] CMD_WRITE = 3'h1;
    localparam logic [2:0] CMD_STORE = 3'h2;
    localparam logic [2:0] CMD_RECALL = 3'h3;
    localparam logic [2:0] CMD_SETCLK = 3'h4;   // set write bit
    localparam logic [2:0] CMD_RUNCLK = 3'h5;   // clear write bit

    // bus cycle request to the pin engine
    typedef struct packed {
        logic write;
        logic [14:0] addr;
        logic [7:0] data;
    } pin_req_s;

    // device pin outputs
    typedef struct packed {
        logic selectN;
        logic strobeN;
        logic outEnN;
        logic [14:0] addr;
    } pin_out_s;
endpackage : nvrtc_pkg

// ===== rtl/nvrtc_cycle.sv
/*
 * pin engine: one select-controlled read or write cycle on the device pins.
 * assumes: request held stable while busy; dataIn already synchronised.
 */
module nvrtc_cycle (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire nvrtc_pkg::pin_req_s req,
    input wire logic [7:0] dataIn,
    output nvrtc_pkg::pin_out_s pins,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic [7:0] rdData,
    output logic done,
    output logic busy
);
    typedef enum logic [1:0] {
        C_IDLE = 2'b00, C_PULSE = 2'b01, C_GAP = 2'b10
    } cyc_e;
    localparam int CW = 8;
    initial assert (nvrtc_pkg::PULSE_CYC < 200 && nvrtc_pkg::GAP_CYC < 200);
    cyc_e state_r;
    logic [CW-1:0] cnt_r;
    logic pulseEnd;
    assign pulseEnd = (cnt_r == CW'(1));

    // ----------------------------------------------------------------
    // sequencer: address set on the same edge that select falls, held past its rise
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= C_IDLE;
            cnt_r <= '0;
            pins <= '{selectN: 1'b1, strobeN: 1'b1, outEnN: 1'b1, addr: '0};
            dataOut <= '0;
            dataOe <= 1'b0;
            rdData <= '0;
            done <= 1'b0;
            busy <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_r)
                C_IDLE: if (start) begin
                    pins.addr <= req.addr;
                    pins.selectN <= 1'b0;
                    pins.strobeN <= ~req.write;
                    pins.outEnN <= req.write;
                    dataOut <= req.data;
                    dataOe <= req.write;
                    cnt_r <= CW'(nvrtc_pkg::PULSE_CYC);
                    busy <= 1'b1;
                    state_r <= C_PULSE;
                end
                C_PULSE: if (pulseEnd) begin
                    pins.selectN <= 1'b1; // data held past this edge
                    pins.strobeN <= 1'b1;
                    pins.outEnN <= 1'b1;
                    rdData <= dataIn;
                    cnt_r <= CW'(nvrtc_pkg::GAP_CYC);
                    state_r <= C_GAP;
                end else begin
                    cnt_r <= cnt_r - CW'(1);
                end
                C_GAP: if (pulseEnd) begin
                    dataOe <= 1'b0;
                    busy <= 1'b0;
                    done <= 1'b1;
                    state_r <= C_IDLE;
                end else begin
                    cnt_r <= cnt_r - CW'(1);
                end
                default: state_r <= C_IDLE;
            endcase
        end
    end
endmodule : nvrtc_cycle

// ===== rtl/nvrtc_host.sv
/*
 * host controller for a byte-wide nonvolatile memory with clock registers.
 * software orders single reads and writes, a software store or recall,
 * and clock set/run over a plain register port; the block drives the pins.
 * assumes: powerFail and supplyLow come from supervisors off this clock.
 */
// Design decisions made here: the placing of the registers and the address-and-strobe port.
module nvrtc_host #(
    parameter int STORE_CYCLES = nvrtc_pkg::STORE_CYC,
    parameter int RECALL_CYCLES = nvrtc_pkg::RESTORE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire logic powerFail,
    input wire logic supplyLow,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic selectN,
    output logic strobeN,
    output logic outEnN,
    output logic [14:0] addr
);
    initial assert (STORE_CYCLES > 1 && RECALL_CYCLES > 1);

    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_ISSUE = 3'b001, S_WAIT = 3'b010,
        S_BUSY = 3'b011, S_HOLD = 3'b100
    } host_e;

    // ----------------------------------------------------------------
    // pin input synchronisers
    // ----------------------------------------------------------------
    logic [7:0] dataMeta_r, dataSync_r;
    logic [1:0] pfMeta_r, pfSync_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dataMeta_r <= '0;
            dataSync_r <= '0;
            pfMeta_r <= 2'h3;
            pfSync_r <= 2'h3;
        end else begin
            dataMeta_r <= dataIn;
            dataSync_r <= dataMeta_r;
            pfMeta_r <= {supplyLow, powerFail};
            pfSync_r <= pfMeta_r;
        end
    end
    wire pfNow = pfSync_r[0];
    wire lowNow = pfSync_r[1];

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    host_e state_r;
    logic [2:0] cmd_r;
    logic [14:0] addr_r;
    logic [7:0] wdata_r, rdata_r;
    logic [2:0] step_r;
    logic [31:0] busyCnt_r;
    logic recallPend_r, dirty_r, refused_r, powerSeen_r;
    logic cycStart, cycDone, cycBusy;
    logic [7:0] cycRd;
    nvrtc_pkg::pin_req_s req;
    nvrtc_pkg::pin_out_s pins;

    // sequence address for each step of the store/recall walk
    function automatic logic [13:0] seqAddr(input logic [2:0] s,
                                            input logic recall);
        case (s)
            3'd0: seqAddr = nvrtc_pkg::SEQ0;
            3'd1: seqAddr = nvrtc_pkg::SEQ1;
            3'd2: seqAddr = nvrtc_pkg::SEQ2;
            3'd3: seqAddr = nvrtc_pkg::SEQ3;
            3'd4: seqAddr = nvrtc_pkg::SEQ4;
            default: seqAddr = recall ? nvrtc_pkg::SEQ_RECALL
                                      : nvrtc_pkg::SEQ_STORE;
        endcase
    endfunction : seqAddr

    // true for plain reads and writes, the only commands run in the hold
    function automatic logic isClkAddrCmd(input logic [2:0] c);
        isClkAddrCmd = c == nvrtc_pkg::CMD_READ || c == nvrtc_pkg::CMD_WRITE;
    endfunction : isClkAddrCmd

    // ----------------------------------------------------------------
    // decode and request selection
    // ----------------------------------------------------------------
    wire cmdGo = regWrite && regAddr == nvrtc_pkg::REG_CMD;
    wire isSeq = cmd_r == nvrtc_pkg::CMD_STORE ||
                 cmd_r == nvrtc_pkg::CMD_RECALL;
    wire isRecall = cmd_r == nvrtc_pkg::CMD_RECALL;
    wire isClk = cmd_r == nvrtc_pkg::CMD_SETCLK ||
                 cmd_r == nvrtc_pkg::CMD_RUNCLK;
    wire inClkSpace = addr_r[14:3] == nvrtc_pkg::CTRL_ADDR[14:3];
    // bit 14 left zero in the sequence: device ignores it anyway
    wire [14:0] seqPin =
        {1'b0, seqAddr(step_r, isRecall)};
    wire [7:0] clkCtl = (cmd_r == nvrtc_pkg::CMD_SETCLK) ?
                        8'h80 : 8'h00;
    wire blockNow = pfNow || (state_r == S_BUSY && !inClkSpace);
    assign req.write = cmd_r == nvrtc_pkg::CMD_WRITE || isClk;
    assign req.addr = isSeq ? seqPin :
                      isClk ? nvrtc_pkg::CTRL_ADDR : addr_r;
    assign req.data = isClk ? clkCtl : wdata_r;
    assign cycStart = state_r == S_ISSUE;
    wire lastStep = !isSeq || step_r == 3'd5;
    wire busyEnd = busyCnt_r == 32'h1;
    wire holdLeft = busyCnt_r > 32'h1;

    // ----------------------------------------------------------------
    // command flow; sequence runs back to back, nothing interleaved
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= S_IDLE;
            cmd_r <= 3'h0;
            step_r <= 3'h0;
            busyCnt_r <= 32'h0;
            refused_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            // hold counter runs down on its own, clock accesses keep it
            if (holdLeft)
                busyCnt_r <= busyCnt_r - 32'h1;
            case (state_r)
                S_IDLE, S_HOLD: if (cmdGo) begin
                    cmd_r <= regWdata[2:0];
                    step_r <= 3'h0;
                    refused_r <= 1'b0;
                    state_r <= (pfNow || (state_r == S_HOLD &&
                                !(isClkAddrCmd(regWdata[2:0]) && inClkSpace)))
                               ? state_r : S_ISSUE;
                    if (pfNow) refused_r <= 1'b1;
                end else if (state_r == S_HOLD && busyEnd) begin
                    state_r <= S_IDLE;
                end
                S_ISSUE: if (blockNow) begin
                    refused_r <= 1'b1; // supply dropped before start
                    state_r <= S_IDLE;
                end else begin
                    state_r <= S_WAIT;
                end
                S_WAIT: if (cycDone) begin
                    rdata_r <= cycRd;
                    step_r <= step_r + 3'h1; // next read follows at once
                    state_r <= !lastStep ? S_ISSUE :
                               isSeq ? S_BUSY :
                               holdLeft ? S_HOLD : S_IDLE;
                    if (lastStep && isSeq)
                        busyCnt_r <= isRecall ? 32'(RECALL_CYCLES)
                                              : 32'(STORE_CYCLES);
                end
                S_BUSY: state_r <= S_HOLD;
                default: state_r <= S_IDLE;
            endcase
            if (powerSeen_r && !pfNow && recallPend_r) begin
                busyCnt_r <= 32'(RECALL_CYCLES);
            end
        end
    end

    // ----------------------------------------------------------------
    // supply tracking: mirror of the device's pending recall and dirty flag
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            recallPend_r <= 1'b1;
            dirty_r <= 1'b0;
            powerSeen_r <= 1'b0;
        end else begin
            powerSeen_r <= pfNow;
            if (lowNow) recallPend_r <= 1'b1;
            else if (powerSeen_r && !pfNow) recallPend_r <= 1'b0;
            if (state_r == S_WAIT && cycDone && req.write && !isClk)
                dirty_r <= 1'b1;
            else if (state_r == S_BUSY || (pfNow && !powerSeen_r))
                dirty_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    logic [31:0] rdNxt;
    always_comb begin
        case (regAddr)
            nvrtc_pkg::REG_ADDR: rdNxt = {17'h0, addr_r};
            nvrtc_pkg::REG_WDATA: rdNxt = {24'h0, wdata_r};
            nvrtc_pkg::REG_RDATA: rdNxt = {24'h0, rdata_r};
            nvrtc_pkg::REG_STATUS: rdNxt = {26'h0, recallPend_r, dirty_r,
                refused_r, pfNow, state_r == S_HOLD || state_r == S_BUSY,
                state_r != S_IDLE};
            default: rdNxt = 32'h0;
        endcase
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_r <= 15'h0;
            wdata_r <= 8'h0;
            regRdata <= 32'h0;
        end else begin
            regRdata <= regRead ? rdNxt : 32'h0;
            if (regWrite && regAddr == nvrtc_pkg::REG_ADDR)
                addr_r <= regWdata[14:0];
            if (regWrite && regAddr == nvrtc_pkg::REG_WDATA)
                wdata_r <= regWdata[7:0]; // software's content
        end
    end

    // ----------------------------------------------------------------
    // pin engine and output flops (engine outputs are flops already)
    // ----------------------------------------------------------------
    nvrtc_cycle cyc (
        .clk(clk),
        .rst(rst),
        .start(cycStart && !blockNow && !cycBusy),
        .req(req),
        .dataIn(dataSync_r),
        .pins(pins),
        .dataOut(dataOut),
        .dataOe(dataOe),
        .rdData(cycRd),
        .done(cycDone),
        .busy(cycBusy)
    );
    assign selectN = pins.selectN; // idle high after reset
    assign strobeN = pins.strobeN;
    assign outEnN = pins.outEnN;
    assign addr = pins.addr;
endmodule : nvrtc_host

// ===== verif/nvrtc_host_sva.sv
/*
 * pin-level checker for the nonvolatile memory host controller.
 * assumes: bound to nvrtc_host; one clock, asynchronous active-high reset.
 */
module nvrtc_host_sva #(
    parameter int STORE_CYCLES = 20,
    parameter int RECALL_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic powerFail,
    input wire logic supplyLow,
    input wire logic [7:0] dataIn,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    input wire logic selectN,
    input wire logic strobeN,
    input wire logic outEnN,
    input wire logic [14:0] addr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // bus cycle shape
    // ------------------------------------------------------------
    a_strobe_in_select: assert property (!strobeN |-> !selectN)
        else $error("strobe low outside select");
    a_addr_held: assert property (
        !selectN && !$past(selectN) |-> $stable(addr))
        else $error("address moved inside a cycle");
    a_data_held: assert property (
        !strobeN && !$past(strobeN) |-> $stable(dataOut))
        else $error("write data moved during strobe");
    a_data_past_end: assert property (
        $rose(strobeN) |-> dataOe ##1 dataOe)
        else $error("write data released at cycle end");
    a_oe_off_write: assert property (!strobeN |-> outEnN && dataOe)
        else $error("output enable low or data off during write");
    a_no_contention: assert property (!outEnN |-> !dataOe)
        else $error("host drives data while outputs enabled");
    a_select_width: assert property (
        $fell(selectN) |-> !selectN[*6] ##1 selectN[*3])
        else $error("select pulse or gap length wrong");
    a_fail_quiet: assert property (powerFail[*8] |-> !$fell(selectN))
        else $error("cycle started during power fail");

    // main scenarios
    c_write: cover property ($fell(selectN) && !strobeN);
    c_read: cover property ($fell(selectN) && strobeN);
    c_fail: cover property (powerFail[*8]);
endmodule : nvrtc_host_sva

bind nvrtc_host nvrtc_host_sva #(.STORE_CYCLES(STORE_CYCLES),
    .RECALL_CYCLES(RECALL_CYCLES)) i_sva (.clk(clk), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .powerFail(powerFail),
    .supplyLow(supplyLow), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .selectN(selectN), .strobeN(strobeN),
    .outEnN(outEnN), .addr(addr));

// ===== verif/nvrtc_dev_model.sv
/*
 * behavioural model of the byte-wide memory with clock registers.
 * assumes: pins driven by the host controller; supply states as levels.
 */
module nvrtc_dev_model #(
    parameter int STORE_NS = 1500,
    parameter int RECALL_NS = 60
) (
    input wire logic selectN,
    input wire logic strobeN,
    input wire logic outEnN,
    input wire logic [14:0] addr,
    input wire logic [7:0] hostData,
    input wire logic hostOe,
    input wire logic powerFail,
    input wire logic supplyLow,
    output logic [7:0] dataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:32767];
    logic [7:0] nv [0:32767];
    logic [7:0] rtc [0:7];
    logic [7:0] last = 8'h00;
    int storeCount = 0;
    int recallCount = 0;
    int seqIdx = 0;
    bit busy = 0;
    bit dirty = 0;
    bit recallReq = 0;
    // access decode; array shut while busy, clock registers stay open
    wire isClk = (addr[14:3] == 12'hfff);
    wire [13:0] low14 = addr[13:0];
    wire blocked = powerFail || (busy && !isClk);
    wire wrAct = !selectN && !strobeN;
    wire rdAct = !selectN && strobeN;
    wire devDrive = rdAct && !outEnN && !blocked;
    wire [7:0] rdVal = isClk ? rtc[addr[2:0]] : mem[addr];
    // a released line shows the inverse of its last level
    assign dataIn = devDrive ? rdVal : (hostOe ? hostData : ~last);
    always @(dataIn) if (devDrive || hostOe) last = dataIn;

    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 8'h00;
            nv[i] = 8'h00;
        end
        for (int i = 0; i < 8; i++) rtc[i] = 8'h00;
    end

    function automatic logic [13:0] seqAt(input int i);
        case (i)
            0: return nvrtc_pkg::SEQ0;
            1: return nvrtc_pkg::SEQ1;
            2: return nvrtc_pkg::SEQ2;
            3: return nvrtc_pkg::SEQ3;
            default: return nvrtc_pkg::SEQ4;
        endcase
    endfunction : seqAt

    // store and recall touch the array only, never the clock registers
    task automatic doStore();
        busy = 1;
        for (int i = 0; i < 32768; i++) nv[i] = mem[i];
        storeCount++;
        dirty = 0;
        fork
            #(STORE_NS) busy = 0;
        join_none
    endtask : doStore
    task automatic doRecall();
        busy = 1;
        for (int i = 0; i < 32768; i++) mem[i] = 8'h00;
        for (int i = 0; i < 32768; i++) mem[i] = nv[i];
        recallCount++;
        dirty = 0;
        fork
            #(RECALL_NS) busy = 0;
        join_none
    endtask : doRecall

    // the byte is taken at the edge that ends the write
    always @(negedge wrAct) if ($time > 0) begin
        seqIdx = 0;
        if (!blocked && isClk) rtc[addr[2:0]] = hostData;
        else if (!blocked) begin
            mem[addr] = hostData;
            dirty = 1;
        end
    end

    // sequence detector stepped by the end of each select read
    always @(negedge rdAct) if ($time > 0 && !blocked) begin
        if (seqIdx == 5 && low14 == nvrtc_pkg::SEQ_STORE) begin
            seqIdx = 0;
            doStore();
        end else if (seqIdx == 5 && low14 == nvrtc_pkg::SEQ_RECALL) begin
            seqIdx = 0;
            doRecall();
        end else if (seqIdx < 5 && low14 == seqAt(seqIdx)) seqIdx++;
        else seqIdx = (low14 == nvrtc_pkg::SEQ0) ? 1 : 0;
    end

    // supply events
    always @(posedge powerFail) if (dirty) doStore();
    always @(posedge supplyLow) recallReq = 1;
    always @(negedge powerFail) if (recallReq) begin
        recallReq = 0;
        doRecall();
    end
    // seconds bit zero toggles at 512 Hz while the test bit is set
    always #976562.5
        if (rtc[4][nvrtc_pkg::DAY_FT_BIT]) rtc[1][0] = ~rtc[1][0];
endmodule : nvrtc_dev_model

// ===== verif/nvrtc_host_bench.sv
/*
 * self-checking bench for the nonvolatile memory host controller.
 * assumes: device model nvrtc_dev_model and the bound pin checker.
 */
module nvrtc_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdata;
    logic powerFail = 1'b0;
    logic supplyLow = 1'b0;
    logic [7:0] dataIn;
    logic [7:0] dataOut;
    logic dataOe;
    logic selectN;
    logic strobeN;
    logic outEnN;
    logic [14:0] addr;
    int mismatches = 0;
    int checkCount = 0;
    int seed = 97;
    int cycles = 0;
    logic [7:0] refMem [int];
    logic [7:0] refNv [int];
    logic [31:0] rd;

    always #2.5 clk = ~clk;

    nvrtc_host #(.STORE_CYCLES(400), .RECALL_CYCLES(20)) i_dut (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .powerFail(powerFail), .supplyLow(supplyLow), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .selectN(selectN),
        .strobeN(strobeN), .outEnN(outEnN), .addr(addr));
    nvrtc_dev_model #(.STORE_NS(1500), .RECALL_NS(60)) i_dev (
        .selectN(selectN), .strobeN(strobeN), .outEnN(outEnN),
        .addr(addr), .hostData(dataOut), .hostOe(dataOe),
        .powerFail(powerFail), .supplyLow(supplyLow), .dataIn(dataIn));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic regWr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : regWr
    task automatic regRd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(posedge clk);
        d = regRdata;
    endtask : regRd
    task automatic waitClr(input logic [31:0] mask);
        logic [31:0] s;
        s = mask;
        for (int i = 0; i < 2000 && (s & mask) != 0; i++)
            regRd(nvrtc_pkg::REG_STATUS, s);
    endtask : waitClr
    task automatic doCmd(input logic [2:0] c, input logic [14:0] a,
                         input logic [7:0] d, input logic [31:0] mask);
        regWr(nvrtc_pkg::REG_ADDR, {17'h0, a});
        regWr(nvrtc_pkg::REG_WDATA, {24'h0, d});
        regWr(nvrtc_pkg::REG_CMD, {29'h0, c});
        waitClr(mask);
    endtask : doCmd
    task automatic readByte(input logic [14:0] a, output logic [7:0] b);
        logic [31:0] r;
        doCmd(nvrtc_pkg::CMD_READ, a, 8'h00, 32'h1);
        regRd(nvrtc_pkg::REG_RDATA, r);
        b = r[7:0];
    endtask : readByte
    task automatic endOfTest();
        if (mismatches == 0 && checkCount > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : endOfTest

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            endOfTest();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] b;
        logic [7:0] d;
        logic [14:0] a;
        logic [14:0] q[$];
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // random writes, then read each back
        for (int i = 0; i < 6; i++) begin
            a = 15'($random(seed)) & 15'h3fff;
            d = 8'($random(seed));
            doCmd(nvrtc_pkg::CMD_WRITE, a, d, 32'h1);
            refMem[a] = d;
            q.push_back(a);
        end
        foreach (q[i]) begin
            readByte(q[i], b);
            check(32'(b), 32'(refMem[q[i]]));
        end
        regRd(nvrtc_pkg::REG_STATUS, rd);
        check(32'(rd[4]), 32'h1);
        // clock set and run
        doCmd(nvrtc_pkg::CMD_SETCLK, 15'h0, 8'h00, 32'h1);
        readByte(nvrtc_pkg::CTRL_ADDR, b);
        check(32'(b), 32'h80);
        doCmd(nvrtc_pkg::CMD_WRITE, nvrtc_pkg::SECONDS_ADDR, 8'h59, 32'h1);
        doCmd(nvrtc_pkg::CMD_RUNCLK, 15'h0, 8'h00, 32'h1);
        readByte(nvrtc_pkg::CTRL_ADDR, b);
        check(32'(b), 32'h00);
        // software store with a clock read during the hold
        doCmd(nvrtc_pkg::CMD_STORE, 15'h0, 8'h00, 32'h0);
        repeat (80) @(posedge clk);
        regRd(nvrtc_pkg::REG_STATUS, rd);
        check(32'(rd[1]), 32'h1);
        readByte(nvrtc_pkg::SECONDS_ADDR, b);
        check(32'(b), 32'h59);
        waitClr(32'h3);
        check(i_dev.storeCount, 1);
        refNv = refMem;
        // overwrite, then recall restores the stored byte
        doCmd(nvrtc_pkg::CMD_WRITE, q[0], ~refMem[q[0]], 32'h1);
        doCmd(nvrtc_pkg::CMD_RECALL, 15'h0, 8'h00, 32'h3);
        readByte(q[0], b);
        check(32'(b), 32'(refNv[q[0]]));
        check(i_dev.recallCount, 1);
        // power loss: automatic store, refused write, recall on return
        doCmd(nvrtc_pkg::CMD_WRITE, q[1], 8'h5a, 32'h1);
        refMem[q[1]] = 8'h5a;
        powerFail <= 1'b1;
        repeat (10) @(posedge clk);
        check(i_dev.storeCount, 2);
        doCmd(nvrtc_pkg::CMD_WRITE, q[2], ~refMem[q[2]], 32'h1);
        regRd(nvrtc_pkg::REG_STATUS, rd);
        check(32'(rd[3:2]), 32'h3);
        supplyLow <= 1'b1;
        repeat (4) @(posedge clk);
        supplyLow <= 1'b0;
        powerFail <= 1'b0;
        repeat (40) @(posedge clk);
        check(i_dev.recallCount, 2);
        powerFail <= 1'b1;
        repeat (10) @(posedge clk);
        powerFail <= 1'b0;
        repeat (40) @(posedge clk);
        check(i_dev.storeCount, 2);
        readByte(q[2], b);
        check(32'(b), 32'(refMem[q[2]]));
        readByte(q[1], b);
        check(32'(b), 32'h5a);
        endOfTest();
    end
endmodule : nvrtc_host_bench
